// File: pcc_top.sv
// Power and clock control register with regulator, brownout and core-enable logic.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module pcc_top
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic por,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hmaster,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic stop_mode,
  input wire logic proc_core_clk,
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_oe,
  output logic shared_clock_pin_out,
  output logic shared_clock_pin_oe,
  output logic clock_out_enable_q,
  input wire logic reset_pin_in,
  input wire logic reset_pin_port_out,
  input wire logic reset_pin_port_dir,
  output logic reset_pin_out_q,
  output logic reset_pin_oe_q,
  output logic reset_pin_port_in_q,
  output logic ext_reset_req_q,
  input wire logic vdd_below_rst,
  output logic regulator_enable_q,
  output logic brownout_detect_enable_q,
  output logic brownout_reset_q,
  output logic processing_core_enable_q,
  output logic processing_core_reset_q
);
  // ****************************************
  // Bus slave and carrier
  // ****************************************
  pcc_regbus_if rb();

  pcc_ahb_slave u_slave
  (
    .mclk(mclk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hmaster(hmaster),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .rb(rb)
  );

  // The slave never refuses a transfer, so the response is always OKAY.
  always_ff @(posedge mclk)
  begin
    hresp <= 1'b0;
  end

  // ****************************************
  // Pin and analog synchronisers
  // ****************************************
  logic reset_pin_s;
  logic vdd_low_s;

  // Each synchroniser resets to its pin's idle level, so that leaving reset
  // raises neither a false external reset request nor a false brownout.
  pcc_sync #(.WIDTH(1), .RESET_VAL(PCC_RST_PIN_LEVEL)) u_sync_pin
  (
    .mclk(mclk),
    .reset(reset),
    .async_in(reset_pin_in),
    .sync_out(reset_pin_s)
  );

  pcc_sync #(.WIDTH(1), .RESET_VAL(PCC_RST_VDD_LOW)) u_sync_vdd
  (
    .mclk(mclk),
    .reset(reset),
    .async_in(vdd_below_rst),
    .sync_out(vdd_low_s)
  );

  // ****************************************
  // Address decode
  // ****************************************
  logic sel_ctrl;
  logic sel_backup;
  logic wr_ctrl;
  logic wr_backup;
  logic is_supervisor;
  logic [PCC_REG_W-1:0] wdata16;

  assign sel_ctrl = rb.addr == PCC_ADDR_CTRL;
  assign sel_backup = rb.addr == PCC_ADDR_BACKUP0;
  assign wr_ctrl = rb.wr_en && sel_ctrl;
  assign wr_backup = rb.wr_en && sel_backup;
  // The master id is latched with the address phase, so a change of hmaster in
  // the data phase cannot turn a write into a supervisory one.
  assign is_supervisor = rb.master == PCC_SUPERVISOR_ID;
  assign wdata16 = rb.wdata[PCC_REG_W-1:0];

  // ****************************************
  // Control bits
  // ****************************************
  logic clk_out_d;
  logic rst_pin_dis_q;
  logic rst_pin_dis_d;
  logic reg_retain_q;
  logic reg_retain_d;
  logic bod_dis_q;
  logic bod_dis_d;
  logic core_en_d;
  logic stop_q;
  logic stop_entry;
  logic core_en_wr;
  logic [PCC_REG_W-1:0] backup0_q;
  logic [PCC_REG_W-1:0] backup0_d;

  // A write replaces one field of the control register; otherwise the field keeps its value.
  function automatic logic merge_bit
  (
    input logic wr,
    input logic [PCC_REG_W-1:0] wd,
    input int pos,
    input logic cur
  );
    merge_bit = wr ? wd[pos] : cur;
  endfunction

  // Stop entry is the first cycle in which stop mode is seen.
  assign stop_entry = stop_mode && !stop_q;
  assign clk_out_d = merge_bit(wr_ctrl, wdata16, PCC_BIT_CLK_OUT, clock_out_enable_q);
  assign rst_pin_dis_d = merge_bit(wr_ctrl, wdata16, PCC_BIT_RST_PIN_DIS, rst_pin_dis_q);
  assign reg_retain_d = merge_bit(wr_ctrl, wdata16, PCC_BIT_REG_RETAIN, reg_retain_q);
  assign bod_dis_d = merge_bit(wr_ctrl, wdata16, PCC_BIT_BOD_STOP_DIS, bod_dis_q);
  // The processing core's own writes never reach its enable bit.
  assign core_en_wr = wr_ctrl && is_supervisor;
  // Stop entry wins over a write in the same cycle so the core cannot slip past it.
  assign core_en_d = stop_entry ? PCC_RST_CORE_EN :
                     core_en_wr ? wdata16[PCC_BIT_CORE_EN] :
                     processing_core_enable_q;
  assign backup0_d = wr_backup ? wdata16 : backup0_q;

  // ****************************************
  // Control flip-flops
  // ****************************************
  // One field to a block, so each field's reset source is plain to see.
  always_ff @(posedge mclk)
  begin
    if (reset)
      clock_out_enable_q <= PCC_RST_CLK_OUT;
    else
      clock_out_enable_q <= clk_out_d;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      reg_retain_q <= PCC_RST_REG_RETAIN;
    else
      reg_retain_q <= reg_retain_d;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      bod_dis_q <= PCC_RST_BOD_STOP_DIS;
    else
      bod_dis_q <= bod_dis_d;
  end

  // Any supervisory reset clears the enable, so the processing core always restarts held.
  always_ff @(posedge mclk)
  begin
    if (reset)
      processing_core_enable_q <= PCC_RST_CORE_EN;
    else
      processing_core_enable_q <= core_en_d;
  end

  // ****************************************
  // Stop entry tracking
  // ****************************************
  // Only the first cycle of stop mode counts, so the enable may be set again while stopped.
  always_ff @(posedge mclk)
  begin
    if (reset)
      stop_q <= 1'b0;
    else
      stop_q <= stop_mode;
  end

  // ****************************************
  // Power-on domain
  // ****************************************
  // These bits survive ordinary resets; only the power-on reset clears them.
  always_ff @(posedge mclk)
  begin
    if (por)
      rst_pin_dis_q <= PCC_RST_RST_PIN_DIS;
    else
      rst_pin_dis_q <= rst_pin_dis_d;
  end

  // Kept across ordinary resets like the battery-backed word it stands for.
  always_ff @(posedge mclk)
  begin
    if (por)
      backup0_q <= PCC_RST_BACKUP0;
    else
      backup0_q <= backup0_d;
  end

  // ****************************************
  // Read-back
  // ****************************************
  logic [PCC_REG_W-1:0] ctrl_rd;
  logic [PCC_REG_W-1:0] ctrl_view;

  // Reserved bits, and the enable bit as the processing core sees it, read as zero.
  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[PCC_BIT_CLK_OUT] = clock_out_enable_q;
    ctrl_view[PCC_BIT_RST_PIN_DIS] = rst_pin_dis_q;
    ctrl_view[PCC_BIT_REG_RETAIN] = reg_retain_q;
    ctrl_view[PCC_BIT_BOD_STOP_DIS] = bod_dis_q;
    ctrl_view[PCC_BIT_CORE_EN] = processing_core_enable_q && is_supervisor;
  end

  assign ctrl_rd = ctrl_view;
  // Unmapped offsets read as zero and ignore writes.
  assign rb.rdata = sel_ctrl ? {16'h0000, ctrl_rd} :
                    sel_backup ? {16'h0000, backup0_q} : 32'h0000_0000;

  // ****************************************
  // Shared clock pin
  // ****************************************
  // The core clock is steered through a mux rather than a flip-flop: a register
  // at this clock rate could not carry an undivided clock to the pin.
  // Software is expected to leave the serial interface idle meanwhile; its
  // clock is simply overridden, not stopped.
  assign shared_clock_pin_out = clock_out_enable_q ? proc_core_clk : spi_sclk_out;
  assign shared_clock_pin_oe = clock_out_enable_q ? 1'b1 : spi_sclk_oe;

  // ****************************************
  // Reset pin
  // ****************************************
  // The pin is active low; its port direction and output controls act in both settings.
  always_ff @(posedge mclk)
  begin
    if (reset)
      reset_pin_out_q <= 1'b0;
    else
      reset_pin_out_q <= reset_pin_port_out;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      reset_pin_oe_q <= 1'b0;
    else
      reset_pin_oe_q <= reset_pin_port_dir;
  end

  // With the reset function detached the pin still reads back as an ordinary port input.
  always_ff @(posedge mclk)
  begin
    if (reset)
      reset_pin_port_in_q <= 1'b0;
    else
      reset_pin_port_in_q <= reset_pin_s;
  end

  // The request is only raised while the reset function stays attached to the pin.
  always_ff @(posedge mclk)
  begin
    if (reset)
      ext_reset_req_q <= 1'b0;
    else
      ext_reset_req_q <= !rst_pin_dis_q && !reset_pin_s;
  end

  // ****************************************
  // Regulator and brownout
  // ****************************************
  logic reg_en_d;
  logic bod_en_d;

  assign reg_en_d = !stop_mode || reg_retain_q;
  // Detection is dropped only with the regulator off and the disable bit set.
  assign bod_en_d = reg_en_d || !bod_dis_q;

  always_ff @(posedge mclk)
  begin
    if (reset)
      regulator_enable_q <= 1'b1;
    else
      regulator_enable_q <= reg_en_d;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      brownout_detect_enable_q <= 1'b1;
    else
      brownout_detect_enable_q <= bod_en_d;
  end

  // Gating the reset with the enable keeps a stale low-supply level from resetting
  // the device once the comparator has been powered down.
  always_ff @(posedge mclk)
  begin
    if (reset)
      brownout_reset_q <= 1'b0;
    else
      brownout_reset_q <= bod_en_d && vdd_low_s;
  end

  // ****************************************
  // Processing core control
  // ****************************************
  // The core reset follows the same next value as the enable, so the core never
  // runs for a cycle past a stop entry or a reset.
  always_ff @(posedge mclk)
  begin
    if (reset)
      processing_core_reset_q <= 1'b1;
    else
      processing_core_reset_q <= !core_en_d;
  end
endmodule

// File: pcc_pkg.sv
// Constants for the power and clock control block.
package pcc_pkg;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] PCC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PCC_ADDR_BACKUP0 = 8'h10;
  localparam int PCC_ADDR_W = 8;
  localparam int PCC_DATA_W = 32;
  localparam int PCC_REG_W = 16;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int PCC_BIT_CLK_OUT = 2;
  localparam int PCC_BIT_RST_PIN_DIS = 5;
  localparam int PCC_BIT_REG_RETAIN = 6;
  localparam int PCC_BIT_BOD_STOP_DIS = 7;
  localparam int PCC_BIT_CORE_EN = 10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic PCC_RST_CLK_OUT = 1'b0;
  localparam logic PCC_RST_RST_PIN_DIS = 1'b0;
  localparam logic PCC_RST_REG_RETAIN = 1'b0;
  localparam logic PCC_RST_BOD_STOP_DIS = 1'b0;
  localparam logic PCC_RST_CORE_EN = 1'b0;
  localparam logic [15:0] PCC_RST_BACKUP0 = 16'h0000;
  localparam logic PCC_RST_PIN_LEVEL = 1'b1;
  localparam logic PCC_RST_VDD_LOW = 1'b0;

  // ****************************************
  // Bus codes
  // ****************************************
  localparam logic [3:0] PCC_SUPERVISOR_ID = 4'h0;
  localparam logic [1:0] PCC_HTRANS_NONSEQ = 2'h2;
endpackage

// File: pcc_regbus_if.sv
// Register access strobes passed from the bus slave to the register file.
`timescale 1ns/1ps
interface pcc_regbus_if
  import pcc_pkg::*;
();
  logic wr_en;
  logic rd_en;
  logic [PCC_ADDR_W-1:0] addr;
  logic [PCC_DATA_W-1:0] wdata;
  logic [PCC_DATA_W-1:0] rdata;
  logic [3:0] master;

  modport slave_side
  (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    output master,
    input rdata
  );
  modport reg_side
  (
    input wr_en,
    input rd_en,
    input addr,
    input wdata,
    input master,
    output rdata
  );
endinterface

// File: pcc_sync.sv
// Two-flip-flop synchroniser for levels arriving from pins or analog blocks.
`timescale 1ns/1ps
module pcc_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: pcc_ahb_slave.sv
// AHB-Lite slave: writes take no wait state, reads take one.
`timescale 1ns/1ps
module pcc_ahb_slave
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hmaster,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  pcc_regbus_if.slave_side rb
);
  // ****************************************
  // Address phase capture
  // ****************************************
  logic accept;
  logic pend_q;
  logic write_q;
  logic [PCC_ADDR_W-1:0] addr_q;
  logic [3:0] master_q;

  // Only word transfers exist here; hsize is accepted but not checked.
  assign accept = hsel && hready && htrans[1];
  assign rb.wr_en = pend_q && write_q;
  assign rb.rd_en = pend_q && !write_q;
  assign rb.addr = addr_q;
  assign rb.wdata = hwdata;
  assign rb.master = master_q;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pend_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= '0;
      master_q <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
    end
    else
    begin
      pend_q <= accept;
      if (accept)
      begin
        write_q <= hwrite;
        addr_q <= haddr[PCC_ADDR_W-1:0];
        master_q <= hmaster;
      end
      // Reads stall one cycle so hrdata comes from a flip-flop holding settled state.
      hreadyout <= !(accept && !hwrite);
      if (rb.rd_en)
        hrdata <= rb.rdata;
    end
  end
endmodule

// File: pcc_props.sv
// Port-level checks for the power and clock control block.
`timescale 1ns/1ps
module pcc_props
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stop_mode,
  input wire logic proc_core_clk,
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_oe,
  input wire logic shared_clock_pin_out,
  input wire logic shared_clock_pin_oe,
  input wire logic clock_out_enable_q,
  input wire logic regulator_enable_q,
  input wire logic brownout_detect_enable_q,
  input wire logic brownout_reset_q,
  input wire logic processing_core_enable_q,
  input wire logic processing_core_reset_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ****
  // Assertions
  // ****
  a_pin_core_clock: assert property (clock_out_enable_q |-> shared_clock_pin_out == proc_core_clk && shared_clock_pin_oe)
    else $error("shared pin not carrying core clock");
  a_pin_spi_path: assert property (!clock_out_enable_q |-> {shared_clock_pin_out, shared_clock_pin_oe} == {spi_sclk_out, spi_sclk_oe})
    else $error("shared pin not carrying spi clock");
  a_reg_run_on: assert property (!$past(stop_mode) |-> regulator_enable_q)
    else $error("regulator off outside stop");
  a_bod_with_reg: assert property (regulator_enable_q |-> brownout_detect_enable_q)
    else $error("brownout detect off while regulator on");
  a_bod_off_quiet: assert property (!brownout_detect_enable_q && !$past(brownout_detect_enable_q) |-> !brownout_reset_q)
    else $error("brownout reset while comparator off");
  a_stop_core_off: assert property ($rose(stop_mode) |=> !processing_core_enable_q)
    else $error("core enable kept over stop entry");
  a_rst_core_off: assert property ($past(reset) |-> !processing_core_enable_q && processing_core_reset_q)
    else $error("core enable kept over reset");
  a_core_held: assert property (processing_core_reset_q == !processing_core_enable_q)
    else $error("core reset not the inverse of enable");
  a_read_wait: assert property (!hreadyout |=> hreadyout && !hresp)
    else $error("wait state longer than one cycle");

  cover property (clock_out_enable_q);
  cover property ($rose(processing_core_enable_q));
  cover property (brownout_reset_q);
  cover property (stop_mode && !regulator_enable_q);
endmodule

// File: testbench.sv
// Self-checking bench for the power and clock control block.
`timescale 1ns/1ps
module testbench;
  import pcc_pkg::*;
  logic mclk, reset, por, hsel, hwrite, hreadyout, hresp, stop_mode, proc_core_clk, spi_sclk_out, spi_sclk_oe;
  logic reset_pin_in, reset_pin_port_out, reset_pin_port_dir, vdd_below_rst, shared_clock_pin_out;
  logic shared_clock_pin_oe, clock_out_enable_q, reset_pin_out_q, reset_pin_oe_q, reset_pin_port_in_q;
  logic ext_reset_req_q, regulator_enable_q, brownout_detect_enable_q, brownout_reset_q;
  logic processing_core_enable_q, processing_core_reset_q;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] hmaster;
  int miscompares, total_checks;

  pcc_top dut_u (.mclk, .reset, .por, .hsel, .haddr, .htrans, .hwrite, .hsize, .hmaster, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .stop_mode, .proc_core_clk, .spi_sclk_out, .spi_sclk_oe,
    .shared_clock_pin_out, .shared_clock_pin_oe, .clock_out_enable_q, .reset_pin_in, .reset_pin_port_out,
    .reset_pin_port_dir, .reset_pin_out_q, .reset_pin_oe_q, .reset_pin_port_in_q, .ext_reset_req_q,
    .vdd_below_rst, .regulator_enable_q, .brownout_detect_enable_q, .brownout_reset_q,
    .processing_core_enable_q, .processing_core_reset_q);

  // ****
  // Bus and check tasks
  // ****
  task automatic test_done();
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // The slave decides the wait, so the master only bounds it.
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= PCC_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask

  task automatic do_rst(input logic p);
    reset <= 1'b1;
    por <= p;
    tick(3);
    reset <= 1'b0;
    por <= 1'b0;
    tick(2);
    check("no_false_rst", 32'h0, ext_reset_req_q);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****
  // Scenarios
  // ****
  initial
  begin
    {reset, por, hsel, spi_sclk_out, spi_sclk_oe, reset_pin_in} = 6'h3f;
    {hwrite, stop_mode, proc_core_clk, reset_pin_port_out, reset_pin_port_dir, vdd_below_rst} = 6'h0;
    {haddr, hwdata, htrans, hsize, hmaster} = {64'h0, 2'h0, 3'h2, PCC_SUPERVISOR_ID};
    miscompares = 0;
    total_checks = 0;
    do_rst(1'b1);
    rd_chk("ctrl_reset", PCC_ADDR_CTRL, 32'h0);
    check("core_reset", 32'h1, processing_core_reset_q);
    xfer(1'b1, PCC_ADDR_CTRL, 32'hffff_ffff);
    rd_chk("ctrl_mask", PCC_ADDR_CTRL, 32'h0000_04e4);
    check("core_run", 32'h0, processing_core_reset_q);
    proc_core_clk <= 1'b1;
    spi_sclk_out <= 1'b0;
    reset_pin_in <= 1'b0;
    tick(6);
    check("pin_clock", 32'h1, shared_clock_pin_out);
    check("pin_detached", 32'h0, ext_reset_req_q);
    check("pin_port_low", 32'h0, reset_pin_port_in_q);
    hmaster <= 4'h1;
    xfer(1'b1, PCC_ADDR_CTRL, 32'h0);
    rd_chk("ctrl_other", PCC_ADDR_CTRL, 32'h0);
    hmaster <= PCC_SUPERVISOR_ID;
    rd_chk("core_kept", PCC_ADDR_CTRL, 32'h0000_0400);
    reset_pin_port_out <= 1'b1;
    reset_pin_port_dir <= 1'b1;
    tick(6);
    check("pin_reset", 32'h1, ext_reset_req_q);
    check("pin_drive", 32'h1, reset_pin_oe_q);
    check("pin_out", 32'h1, reset_pin_out_q);
    reset_pin_in <= 1'b1;
    xfer(1'b1, PCC_ADDR_CTRL, 32'h0000_0480);
    stop_mode <= 1'b1;
    vdd_below_rst <= 1'b1;
    tick(6);
    check("core_stop", 32'h0, processing_core_enable_q);
    check("reg_stop_off", 32'h0, regulator_enable_q);
    check("bod_off", 32'h0, brownout_reset_q);
    check("bod_det_off", 32'h0, brownout_detect_enable_q);
    check("pin_port_high", 32'h1, reset_pin_port_in_q);
    xfer(1'b1, PCC_ADDR_CTRL, 32'h0);
    tick(4);
    check("bod_stop_on", 32'h1, brownout_reset_q);
    check("pin_spi", 32'h0, shared_clock_pin_out);
    vdd_below_rst <= 1'b0;
    xfer(1'b1, PCC_ADDR_CTRL, 32'h0000_0040);
    tick(3);
    check("reg_retain", 32'h1, regulator_enable_q);
    stop_mode <= 1'b0;
    xfer(1'b1, PCC_ADDR_CTRL, 32'h0000_0024);
    xfer(1'b1, PCC_ADDR_BACKUP0, 32'hffff_abcd);
    do_rst(1'b0);
    rd_chk("rst_keeps", PCC_ADDR_CTRL, 32'h0000_0020);
    rd_chk("backup", PCC_ADDR_BACKUP0, 32'h0000_abcd);
    rd_chk("unmapped", 8'h20, 32'h0);
    do_rst(1'b1);
    rd_chk("por_clears", PCC_ADDR_CTRL, 32'h0);
    test_done();
  end
endmodule

bind pcc_top pcc_props chk_u (.mclk, .reset, .hreadyout, .hresp, .stop_mode, .proc_core_clk, .spi_sclk_out,
  .spi_sclk_oe, .shared_clock_pin_out, .shared_clock_pin_oe, .clock_out_enable_q, .regulator_enable_q,
  .brownout_detect_enable_q, .brownout_reset_q, .processing_core_enable_q, .processing_core_reset_q);
